/* File: bsa_alu.sv */
// Eight-function ALU with carry lookahead terms
module bsa_alu
   import bsa_pkg::*;
#(
   parameter int W = 4
)
(
   input wire logic [W-1:0] r_i,
   input wire logic [W-1:0] s_i,
   input wire bsa_func_t func_i,
   input wire logic carry_i,
   output logic [W-1:0] f_o,
   output logic carry_o,
   output logic gen_n_o,
   output logic prop_n_o
);

   logic [W-1:0] r_eff;
   logic [W-1:0] s_eff;
   logic [W:0] sum;
   logic [W-1:0] g;
   logic [W-1:0] p;
   logic gg;
   logic pp;

   // Subtraction adds the complement of the subtrahend plus carry
   assign r_eff = (func_i == BSA_FN_SUBR) ? ~r_i : r_i;
   assign s_eff = (func_i == BSA_FN_SUBS) ? ~s_i : s_i;
   assign sum = {1'b0, r_eff} + {1'b0, s_eff} + {{W{1'b0}}, carry_i};
   assign g = r_eff & s_eff;
   assign p = r_eff | s_eff;

   always_comb
   begin
      gg = g[0];
      pp = p[0];
      for (int i = 1; i < W; i++)
      begin
         gg = g[i] | (p[i] & gg);
         pp = pp & p[i];
      end
   end

   always_comb
   begin
      case (func_i)
         BSA_FN_ADD,
         BSA_FN_SUBR,
         BSA_FN_SUBS: f_o = sum[W-1:0];
         BSA_FN_OR: f_o = r_i | s_i;
         BSA_FN_AND: f_o = r_i & s_i;
         BSA_FN_NOTRS: f_o = ~r_i & s_i;
         BSA_FN_XOR: f_o = r_i ^ s_i;
         BSA_FN_XNOR: f_o = ~(r_i ^ s_i);
         default: f_o = '0;
      endcase
   end

   assign carry_o = sum[W];
   assign gen_n_o = ~gg;
   assign prop_n_o = ~pp;

endmodule // bsa_alu

/* File: bsa_datapath.sv */
// Top of the 4-bit slice datapath with its bus register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "bsa_params.svh"

module bsa_datapath
   import bsa_pkg::*;
#(
   parameter int W = 4,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire bsa_uinst_t microinstruction_bits_i,
   input wire logic [AW-1:0] a_addr_i,
   input wire logic [AW-1:0] b_addr_i,
   input wire logic [W-1:0] direct_data_i,
   input wire logic carry_input_i,
   input wire logic out_enable_n_i,
   output logic [W-1:0] y_o,
   output logic y_oe_o,
   output logic carry_output_o,
   output logic alu_sign_bit_o,
   output logic gen_n_o,
   output logic prop_n_o,
   input wire logic file_shift_lsb_pin_i,
   output logic file_shift_lsb_pin_o,
   output logic file_shift_lsb_pin_oe_o,
   input wire logic file_shift_msb_pin_i,
   output logic file_shift_msb_pin_o,
   output logic file_shift_msb_pin_oe_o,
   input wire logic aux_shift_lsb_pin_i,
   output logic aux_shift_lsb_pin_o,
   output logic aux_shift_lsb_pin_oe_o,
   input wire logic aux_shift_msb_pin_i,
   output logic aux_shift_msb_pin_o,
   output logic aux_shift_msb_pin_oe_o,
   input wire logic [31:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   input wire logic [31:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i
);

   logic [W-1:0] port_a;
   logic [W-1:0] port_b;
   logic [W-1:0] q_reg;
   logic [W-1:0] r_op;
   logic [W-1:0] s_op;
   logic [W-1:0] f;
   logic alu_carry;
   logic alu_gen_n;
   logic alu_prop_n;
   logic file_we;
   logic [W-1:0] next_file_word;
   logic q_load;
   logic [W-1:0] next_q;
   logic y_from_a;
   logic hold;
   logic aw_got;
   logic w_got;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   bsa_dest_t dest;

   assign dest = microinstruction_bits_i.dest;

   bsa_regfile #(
      .W(W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_regfile (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(file_we),
      .waddr_i(b_addr_i),
      .wdata_i(next_file_word),
      .raddr_a_i(a_addr_i),
      .raddr_b_i(b_addr_i),
      .rdata_a_o(port_a),
      .rdata_b_o(port_b)
   );

   // Operand pair selection; a zero entry is the inhibited multiplexer
   always_comb
   begin
      case (microinstruction_bits_i.src)
         BSA_SRC_AQ:
         begin
            r_op = port_a;
            s_op = q_reg;
         end
         BSA_SRC_AB:
         begin
            r_op = port_a;
            s_op = port_b;
         end
         BSA_SRC_ZQ:
         begin
            r_op = '0;
            s_op = q_reg;
         end
         BSA_SRC_ZB:
         begin
            r_op = '0;
            s_op = port_b;
         end
         BSA_SRC_ZA:
         begin
            r_op = '0;
            s_op = port_a;
         end
         BSA_SRC_DA:
         begin
            r_op = direct_data_i;
            s_op = port_a;
         end
         BSA_SRC_DQ:
         begin
            r_op = direct_data_i;
            s_op = q_reg;
         end
         BSA_SRC_DZ:
         begin
            r_op = direct_data_i;
            s_op = '0;
         end
         default:
         begin
            r_op = '0;
            s_op = '0;
         end
      endcase
   end

   bsa_alu #(
      .W(W)
   ) u_alu (
      .r_i(r_op),
      .s_i(s_op),
      .func_i(microinstruction_bits_i.func),
      .carry_i(carry_input_i),
      .f_o(f),
      .carry_o(alu_carry),
      .gen_n_o(alu_gen_n),
      .prop_n_o(alu_prop_n)
   );

   // Destination decode: file and Q inputs with their shift multiplexers
   always_comb
   begin
      file_we = 1'b0;
      next_file_word = f;
      q_load = 1'b0;
      next_q = f;
      y_from_a = 1'b0;
      case (dest)
         BSA_DST_QREG:
         begin
            q_load = 1'b1;
         end
         BSA_DST_NOP:
         begin
            q_load = 1'b0;
         end
         BSA_DST_RAMA:
         begin
            file_we = 1'b1;
            y_from_a = 1'b1;
         end
         BSA_DST_RAMF:
         begin
            file_we = 1'b1;
         end
         BSA_DST_RAMQD:
         begin
            file_we = 1'b1;
            next_file_word = {file_shift_msb_pin_i, f[W-1:1]};
            q_load = 1'b1;
            next_q = {aux_shift_msb_pin_i, q_reg[W-1:1]};
         end
         BSA_DST_RAMD:
         begin
            file_we = 1'b1;
            next_file_word = {file_shift_msb_pin_i, f[W-1:1]};
         end
         BSA_DST_RAMQU:
         begin
            file_we = 1'b1;
            next_file_word = {f[W-2:0], file_shift_lsb_pin_i};
            q_load = 1'b1;
            next_q = {q_reg[W-2:0], aux_shift_lsb_pin_i};
         end
         BSA_DST_RAMU:
         begin
            file_we = 1'b1;
            next_file_word = {f[W-2:0], file_shift_lsb_pin_i};
         end
         default:
         begin
            file_we = 1'b0;
         end
      endcase
      if (hold)
      begin
         file_we = 1'b0;
         q_load = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q_reg <= '0;
      end
      else if (q_load)
      begin
         q_reg <= next_q;
      end
   end

   // Result and status outputs, registered
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         y_o <= '0;
         y_oe_o <= 1'b0;
         carry_output_o <= 1'b0;
         alu_sign_bit_o <= 1'b0;
         gen_n_o <= 1'b1;
         prop_n_o <= 1'b1;
      end
      else
      begin
         y_o <= y_from_a ? port_a : f;
         y_oe_o <= ~out_enable_n_i;
         carry_output_o <= alu_carry;
         alu_sign_bit_o <= f[W-1];
         gen_n_o <= alu_gen_n;
         prop_n_o <= alu_prop_n;
      end
   end

   // Shift pin drivers: down shifts drive the LSB pins, up shifts the MSB pins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         file_shift_lsb_pin_o <= 1'b0;
         file_shift_lsb_pin_oe_o <= 1'b0;
         file_shift_msb_pin_o <= 1'b0;
         file_shift_msb_pin_oe_o <= 1'b0;
         aux_shift_lsb_pin_o <= 1'b0;
         aux_shift_lsb_pin_oe_o <= 1'b0;
         aux_shift_msb_pin_o <= 1'b0;
         aux_shift_msb_pin_oe_o <= 1'b0;
      end
      else
      begin
         file_shift_lsb_pin_o <= f[0];
         aux_shift_lsb_pin_o <= q_reg[0];
         file_shift_msb_pin_o <= f[W-1];
         aux_shift_msb_pin_o <= q_reg[W-1];
         file_shift_lsb_pin_oe_o <= (dest == BSA_DST_RAMQD) || (dest == BSA_DST_RAMD);
         aux_shift_lsb_pin_oe_o <= (dest == BSA_DST_RAMQD) || (dest == BSA_DST_RAMD);
         file_shift_msb_pin_oe_o <= (dest == BSA_DST_RAMQU) || (dest == BSA_DST_RAMU);
         aux_shift_msb_pin_oe_o <= (dest == BSA_DST_RAMQU) || (dest == BSA_DST_RAMU);
      end
   end

   // Bus write address and data are taken in either order
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         aw_got <= 1'b0;
         s_awready_o <= 1'b0;
         aw_addr <= 8'h00;
      end
      else if (s_awvalid_i && s_awready_o)
      begin
         aw_got <= 1'b1;
         s_awready_o <= 1'b0;
         aw_addr <= s_awaddr_i[7:0];
      end
      else if (s_bvalid_o && s_bready_i)
      begin
         aw_got <= 1'b0;
         s_awready_o <= 1'b1;
      end
      else if (!aw_got)
      begin
         s_awready_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         w_got <= 1'b0;
         s_wready_o <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else if (s_wvalid_i && s_wready_o)
      begin
         w_got <= 1'b1;
         s_wready_o <= 1'b0;
         w_data <= s_wdata_i;
         w_strb <= s_wstrb_i;
      end
      else if (s_bvalid_o && s_bready_i)
      begin
         w_got <= 1'b0;
         s_wready_o <= 1'b1;
      end
      else if (!w_got)
      begin
         s_wready_o <= 1'b1;
      end
   end

   // Write commit and response; status is read-only and ignores writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold <= `BSA_CTRL_RESET;
         s_bvalid_o <= 1'b0;
         s_bresp_o <= `BSA_RESP_OKAY;
      end
      else if (aw_got && w_got && !s_bvalid_o)
      begin
         s_bvalid_o <= 1'b1;
         s_bresp_o <= `BSA_RESP_OKAY;
         if (aw_addr == `BSA_CTRL_OFF)
         begin
            if (w_strb[0])
            begin
               hold <= w_data[`BSA_CTRL_HOLD_BIT];
            end
         end
         else if (aw_addr != `BSA_STATUS_OFF)
         begin
            s_bresp_o <= `BSA_RESP_SLVERR;
         end
      end
      else if (s_bvalid_o && s_bready_i)
      begin
         s_bvalid_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_arready_o <= 1'b0;
         s_rvalid_o <= 1'b0;
         s_rdata_o <= 32'h0000_0000;
         s_rresp_o <= `BSA_RESP_OKAY;
      end
      else if (s_arvalid_i && s_arready_o)
      begin
         s_arready_o <= 1'b0;
         s_rvalid_o <= 1'b1;
         s_rdata_o <= 32'h0000_0000;
         s_rresp_o <= `BSA_RESP_OKAY;
         if (s_araddr_i[7:0] == `BSA_CTRL_OFF)
         begin
            s_rdata_o[`BSA_CTRL_HOLD_BIT] <= hold;
         end
         else if (s_araddr_i[7:0] == `BSA_STATUS_OFF)
         begin
            s_rdata_o[`BSA_ST_Q_LSB +: W] <= q_reg;
            s_rdata_o[`BSA_ST_Y_LSB +: W] <= y_o;
            s_rdata_o[`BSA_ST_CARRY_BIT] <= carry_output_o;
            s_rdata_o[`BSA_ST_SIGN_BIT] <= alu_sign_bit_o;
            s_rdata_o[`BSA_ST_HOLD_BIT] <= hold;
         end
         else
         begin
            s_rresp_o <= `BSA_RESP_SLVERR;
         end
      end
      else if (s_rvalid_o && s_rready_i)
      begin
         s_rvalid_o <= 1'b0;
         s_arready_o <= 1'b1;
      end
      else if (!s_rvalid_o)
      begin
         s_arready_o <= 1'b1;
      end
   end

endmodule // bsa_datapath

/* File: bsa_datapath_properties.sv */
// Port-level timing checks for the slice datapath
module bsa_datapath_properties
   import bsa_pkg::*;
#(
   parameter int W = 4,
   parameter int AW = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire bsa_uinst_t microinstruction_bits_i,
   input wire logic [AW-1:0] a_addr_i,
   input wire logic [AW-1:0] b_addr_i,
   input wire logic [W-1:0] direct_data_i,
   input wire logic carry_input_i,
   input wire logic [W-1:0] y_o,
   input wire logic carry_output_o,
   input wire logic alu_sign_bit_o,
   input wire logic file_shift_msb_pin_o,
   input wire logic file_shift_lsb_pin_oe_o,
   input wire logic file_shift_msb_pin_oe_o,
   input wire logic aux_shift_lsb_pin_oe_o,
   input wire logic aux_shift_msb_pin_oe_o
);
   logic [2:0] dst, fn, sr;
   assign {dst, fn, sr} = microinstruction_bits_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_pass_d;
      sr == 3'h7 && fn == 3'h3 && dst != 3'h2;
   endsequence
   sequence s_zero_q;
      sr == 3'h2 && fn == 3'h4 && dst != 3'h2;
   endsequence
   sequence s_same_xor;
      a_addr_i == b_addr_i && sr == 3'h1 && fn == 3'h6 && dst != 3'h2;
   endsequence
   sequence s_add_d;
      sr == 3'h7 && fn == 3'h0 && dst != 3'h2;
   endsequence
   a_pass_direct: assert property (s_pass_d |=> y_o == $past(direct_data_i))
      else $error("direct data not passed to y");
   a_zero_inhibit: assert property (s_zero_q |=> y_o == 4'h0)
      else $error("inhibited operand not zero");
   a_equal_ports: assert property (s_same_xor |=> y_o == 4'h0)
      else $error("equal addresses gave unequal words");
   a_carry_high: assert property (s_add_d |=> carry_output_o ==
      ($past(direct_data_i) == 4'hF && $past(carry_input_i)))
      else $error("carry out wrong for D plus carry");
   a_sign_msb: assert property (dst != 3'h2 |=> alu_sign_bit_o == y_o[3])
      else $error("sign output differs from result msb");
   a_left_drive: assert property (dst[2:1] == 2'h3 |=>
      file_shift_msb_pin_oe_o && aux_shift_msb_pin_oe_o)
      else $error("msb shift pins not driven on left shift");
   a_msb_released: assert property (dst[2:1] != 2'h3 |=>
      !file_shift_msb_pin_oe_o && !aux_shift_msb_pin_oe_o)
      else $error("msb shift pins driven outside left shift");
   a_quiet_pins: assert property (!dst[2] |=>
      !(file_shift_lsb_pin_oe_o || aux_shift_lsb_pin_oe_o))
      else $error("lsb shift pins driven in no-shift mode");
   a_msb_sign_out: assert property (file_shift_msb_pin_oe_o |->
      file_shift_msb_pin_o == y_o[3])
      else $error("file msb pin not the result msb");
endmodule // bsa_datapath_properties

bind bsa_datapath bsa_datapath_properties #(.W(W), .AW(AW)) u_props (
   .clk_i, .rst_i, .microinstruction_bits_i, .a_addr_i, .b_addr_i, .direct_data_i,
   .carry_input_i, .y_o, .carry_output_o, .alu_sign_bit_o, .file_shift_msb_pin_o,
   .file_shift_lsb_pin_oe_o, .file_shift_msb_pin_oe_o, .aux_shift_lsb_pin_oe_o,
   .aux_shift_msb_pin_oe_o
);

/* File: bsa_params.svh */
// Register offsets, field positions and reset values of the slice's bus registers
`ifndef BSA_PARAMS_SVH
`define BSA_PARAMS_SVH

`define BSA_CTRL_OFF 8'h00
`define BSA_STATUS_OFF 8'h04
`define BSA_CTRL_HOLD_BIT 0
`define BSA_CTRL_RESET 1'h0
`define BSA_ST_Q_LSB 0
`define BSA_ST_Y_LSB 4
`define BSA_ST_CARRY_BIT 8
`define BSA_ST_SIGN_BIT 9
`define BSA_ST_HOLD_BIT 10
`define BSA_RESP_OKAY 2'h0
`define BSA_RESP_SLVERR 2'h2

`endif

/* File: bsa_pkg.sv */
// Types shared by the slice datapath modules
package bsa_pkg;

   typedef enum logic [2:0] {
      BSA_SRC_AQ = 3'h0,
      BSA_SRC_AB = 3'h1,
      BSA_SRC_ZQ = 3'h2,
      BSA_SRC_ZB = 3'h3,
      BSA_SRC_ZA = 3'h4,
      BSA_SRC_DA = 3'h5,
      BSA_SRC_DQ = 3'h6,
      BSA_SRC_DZ = 3'h7
   } bsa_src_t;

   typedef enum logic [2:0] {
      BSA_FN_ADD = 3'h0,
      BSA_FN_SUBR = 3'h1,
      BSA_FN_SUBS = 3'h2,
      BSA_FN_OR = 3'h3,
      BSA_FN_AND = 3'h4,
      BSA_FN_NOTRS = 3'h5,
      BSA_FN_XOR = 3'h6,
      BSA_FN_XNOR = 3'h7
   } bsa_func_t;

   typedef enum logic [2:0] {
      BSA_DST_QREG = 3'h0,
      BSA_DST_NOP = 3'h1,
      BSA_DST_RAMA = 3'h2,
      BSA_DST_RAMF = 3'h3,
      BSA_DST_RAMQD = 3'h4,
      BSA_DST_RAMD = 3'h5,
      BSA_DST_RAMQU = 3'h6,
      BSA_DST_RAMU = 3'h7
   } bsa_dest_t;

   // Microinstruction word: destination in 8..6, function in 5..3, source in 2..0
   typedef struct packed {
      bsa_dest_t dest;
      bsa_func_t func;
      bsa_src_t src;
   } bsa_uinst_t;

endpackage

/* File: bsa_regfile.sv */
// Two-read one-write register file of the slice
module bsa_regfile
   import bsa_pkg::*;
#(
   parameter int W = 4,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_a_i,
   input wire logic [AW-1:0] raddr_b_i,
   output logic [W-1:0] rdata_a_o,
   output logic [W-1:0] rdata_b_o
);

   logic [W-1:0] mem [DEPTH];

   // Reads see the words as they stood before this edge's write
   assign rdata_a_o = mem[raddr_a_i];
   assign rdata_b_o = mem[raddr_b_i];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
      end
      else if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

endmodule // bsa_regfile

/* File: bsa_shift_partner.sv */
// Neighbouring slice that drives the shift pins whenever this slice releases them
module bsa_shift_partner
(
   input wire logic clk_i,
   input wire logic [3:0] oe_i,
   input wire logic [3:0] o_i,
   output logic [3:0] pin_o,
   output logic [3:0] drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] drv = 4'h3;
   // Changes every cycle so a stale level never passes for shifted data
   always_ff @(posedge clk_i)
      drv <= drv + 4'h5;
   assign drive_o = drv;
   assign pin_o = (oe_i & o_i) | (~oe_i & drv);
endmodule // bsa_shift_partner

/* File: testbench.sv */
// Self-checking bench: slice datapath against a cycle model
`include "bsa_params.svh"

module testbench
   import bsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   bsa_uinst_t ui = 9'h040;
   logic [3:0] a_addr_i = 4'h0, b_addr_i = 4'h0, dd = 4'h0;
   logic cin = 1'h0, oen = 1'h0, hold = 1'h0;
   logic [31:0] s_awaddr_i = 32'h0, s_wdata_i = 32'h0, s_araddr_i = 32'h0;
   logic s_awvalid_i = 1'h0, s_wvalid_i = 1'h0, s_bready_i = 1'h0;
   logic s_arvalid_i = 1'h0, s_rready_i = 1'h0;
   logic [3:0] y_o, po_d, poe_d, pin, drv, q, ey, po, poe;
   logic [3:0] mem [16];
   logic y_oe_o, carry_output_o, alu_sign_bit_o, s_awready_o, s_wready_o;
   logic s_bvalid_o, s_arready_o, s_rvalid_o, ec, es, gn, pn, eg, ep;
   logic [1:0] s_bresp_o, s_rresp_o;
   logic [31:0] s_rdata_o;
   int mismatches = 0;
   int tests_run = 0;

   bsa_datapath uut (
      .clk_i, .rst_i, .microinstruction_bits_i(ui), .a_addr_i, .b_addr_i,
      .direct_data_i(dd), .carry_input_i(cin), .out_enable_n_i(oen), .y_o, .y_oe_o,
      .carry_output_o, .alu_sign_bit_o, .gen_n_o(gn), .prop_n_o(pn),
      .file_shift_lsb_pin_i(pin[0]), .file_shift_lsb_pin_o(po_d[0]),
      .file_shift_lsb_pin_oe_o(poe_d[0]), .file_shift_msb_pin_i(pin[1]),
      .file_shift_msb_pin_o(po_d[1]), .file_shift_msb_pin_oe_o(poe_d[1]),
      .aux_shift_lsb_pin_i(pin[2]), .aux_shift_lsb_pin_o(po_d[2]),
      .aux_shift_lsb_pin_oe_o(poe_d[2]), .aux_shift_msb_pin_i(pin[3]),
      .aux_shift_msb_pin_o(po_d[3]), .aux_shift_msb_pin_oe_o(poe_d[3]),
      .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i(4'hF),
      .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
      .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i
   );
   bsa_shift_partner nb (.clk_i, .oe_i(poe_d), .o_i(po_d), .pin_o(pin), .drive_o(drv));

   always #4 clk_i = ~clk_i;

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Cycle model; pins order: aux msb, aux lsb, file msb, file lsb
   always @(posedge clk_i)
   begin : model
      logic [3:0] a, b, r, s, f, w, re, se;
      logic [4:0] sum;
      logic ari, eoe;
      if (rst_i)
      begin
         foreach (mem[i])
            mem[i] = 4'h0;
         q = 4'h0;
         poe = 4'h0;
         hold = 1'h0;
      end
      else
      begin
         a = mem[a_addr_i];
         b = mem[b_addr_i];
         case (ui.src)
            BSA_SRC_AQ: {r, s} = {a, q};
            BSA_SRC_AB: {r, s} = {a, b};
            BSA_SRC_ZQ: {r, s} = {4'h0, q};
            BSA_SRC_ZB: {r, s} = {4'h0, b};
            BSA_SRC_ZA: {r, s} = {4'h0, a};
            BSA_SRC_DA: {r, s} = {dd, a};
            BSA_SRC_DQ: {r, s} = {dd, q};
            default: {r, s} = {dd, 4'h0};
         endcase
         case (ui.func)
            BSA_FN_ADD: sum = r + s + cin;
            BSA_FN_SUBR: sum = s + {1'h0, ~r} + cin;
            BSA_FN_SUBS: sum = r + {1'h0, ~s} + cin;
            BSA_FN_OR: sum = r | s;
            BSA_FN_AND: sum = r & s;
            BSA_FN_NOTRS: sum = ~r & s;
            BSA_FN_XOR: sum = r ^ s;
            default: sum = ~(r ^ s);
         endcase
         f = sum[3:0];
         // Lookahead terms: subtractions see the complemented operand
         re = (ui.func == BSA_FN_SUBR) ? ~r : r;
         se = (ui.func == BSA_FN_SUBS) ? ~s : s;
         eg = !(5'(re) + 5'(se) > 5'hF);
         ep = !(&(re | se));
         w = (poe & po) | (~poe & drv);
         ey = (ui.dest == BSA_DST_RAMA) ? a : f;
         ec = sum[4];
         es = f[3];
         eoe = !oen;
         ari = ui.func < BSA_FN_OR;
         po = {q[3], q[0], f[3], f[0]};
         poe = {2{ui.dest[2:1] == 2'h3, ui.dest[2:1] == 2'h2}};
         if (!hold)
         begin
            case (ui.dest)
               BSA_DST_QREG: q = f;
               BSA_DST_RAMA, BSA_DST_RAMF: mem[b_addr_i] = f;
               BSA_DST_RAMQD: {mem[b_addr_i], q} = {w[1], f[3:1], w[3], q[3:1]};
               BSA_DST_RAMD: mem[b_addr_i] = {w[1], f[3:1]};
               BSA_DST_RAMQU: {mem[b_addr_i], q} = {f[2:0], w[0], q[2:0], w[2]};
               BSA_DST_RAMU: mem[b_addr_i] = {f[2:0], w[0]};
               default: ;
            endcase
         end
         #1;
         cmp(32'({y_oe_o, alu_sign_bit_o, y_o}), 32'({eoe, es, ey}));
         cmp(32'({poe_d, po_d & poe_d}), 32'({poe, po & poe}));
         cmp(32'({gn, pn}), 32'({eg, ep}));
         if (ari)
            cmp(32'(carry_output_o), 32'(ec));
      end
   end

   task automatic run(input int n, input bit sweep);
      logic [3:0] ad;
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk_i);
         ad = 4'($urandom);
         ui <= sweep ? 9'(k) : 9'($urandom);
         a_addr_i <= ad;
         b_addr_i <= sweep ? ad : 4'($urandom);
         dd <= 4'($urandom);
         cin <= 1'($urandom);
         oen <= 1'($urandom);
      end
   endtask

   task automatic idle();
      @(posedge clk_i);
      ui <= 9'h040;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic axw(input logic [31:0] ad, input logic [31:0] dat, input logic [1:0] er);
      logic ga, gw;
      ga = 1'h0;
      gw = 1'h0;
      @(posedge clk_i);
      s_awaddr_i <= ad;
      s_wdata_i <= dat;
      s_awvalid_i <= 1'h1;
      s_wvalid_i <= 1'h1;
      s_bready_i <= 1'h1;
      while (!(ga && gw))
      begin
         @(posedge clk_i);
         if (s_awready_o)
         begin
            ga = 1'h1;
            s_awvalid_i <= 1'h0;
         end
         if (s_wready_o)
         begin
            gw = 1'h1;
            s_wvalid_i <= 1'h0;
         end
      end
      do
         @(posedge clk_i);
      while (!s_bvalid_o);
      s_bready_i <= 1'h0;
      cmp(32'(s_bresp_o), 32'(er));
   endtask

   task automatic axr(input logic [31:0] ad, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_i);
      s_araddr_i <= ad;
      s_arvalid_i <= 1'h1;
      s_rready_i <= 1'h1;
      do
         @(posedge clk_i);
      while (!s_arready_o);
      s_arvalid_i <= 1'h0;
      do
         @(posedge clk_i);
      while (!s_rvalid_o);
      s_rready_i <= 1'h0;
      cmp(s_rdata_o, ed);
      cmp(32'(s_rresp_o), 32'(er));
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      void'($urandom(39541));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      run(512, 1'h1);
      $display("test sweep of all codes done");
      run(800, 1'h0);
      $display("test random sequence done");
      idle();
      axw({24'h0, `BSA_CTRL_OFF}, 32'h1, `BSA_RESP_OKAY);
      hold = 1'h1;
      run(60, 1'h0);
      idle();
      axr({24'h0, `BSA_STATUS_OFF}, {21'h0, hold, es, ec, ey, q}, `BSA_RESP_OKAY);
      axw({24'h0, `BSA_CTRL_OFF}, 32'h0, `BSA_RESP_OKAY);
      hold = 1'h0;
      axw({24'h0, `BSA_STATUS_OFF}, 32'hFFFF, `BSA_RESP_OKAY);
      axw(32'h8, 32'h1, `BSA_RESP_SLVERR);
      axr(32'hC, 32'h0, `BSA_RESP_SLVERR);
      axr({24'h0, `BSA_CTRL_OFF}, 32'h0, `BSA_RESP_OKAY);
      $display("test register access done");
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      run(200, 1'h0);
      $display("test reset in mid-run done");
      give_verdict();
   end

   initial
   begin
      #100us;
      mismatches++;
      give_verdict();
   end
endmodule // testbench
